// [logic/eesu_top.sv]
// Upper error-event status, enables, interrupt and diagnosis registers
`timescale 1ns/1ps
module eesu_top
    import eesu_pkg::*;
#(
    parameter int PTR_W = 32
) (
    input  wire logic             core_clk,
    input  wire logic             rst_b,
    input  wire logic             ce,
    // Register port
    input  wire logic [7:0]       regAddr,
    input  wire logic [15:0]      regWrData,
    input  wire logic             regWrStb,
    input  wire logic             regRdStb,
    output logic      [15:0]      regRdData,
    output logic                  irq,
    // Mode and configuration
    input  wire logic             primaryMode,
    input  wire logic             hsSeMode,
    input  wire logic             respCheckEn,
    // Error sources
    input  wire logic [3:0]       vendorErr,
    input  wire logic             respErr,
    input  wire logic             tuningFault,
    input  wire logic             tuningActive,
    input  wire logic             dmaErr,
    input  wire logic             descFetchInvalid,
    input  wire logic [2:0]       dmaState,
    input  wire logic [PTR_W-1:0] descAddr,
    input  wire logic [7:0]       acmdErrBits,
    input  wire logic             acmdIsCmd12,
    // Fault during tuning, handed to the sampling clock choice logic
    output logic                  sampleSelFault
);

    // ======================================================================
    // Helpers

    // Sticky update; the set term is applied last so it wins over a clear
    function automatic logic [15:0] eesu_sticky(input logic [15:0] cur,
                                                input logic [15:0] clr,
                                                input logic [15:0] set);
        eesu_sticky = (cur & ~clr) | set;
    endfunction : eesu_sticky

    function automatic logic eesu_hit(input logic [7:0] addr, input logic [7:0] off);
        eesu_hit = (addr == off);
    endfunction : eesu_hit

    // ======================================================================
    // State

    logic [15:0]      flagsQ,    flagsD;
    logic [15:0]      statEnQ,   statEnD;
    logic [15:0]      sigEnQ,    sigEnD;
    logic [2:0]       dmaStQ,    dmaStD;
    logic [PTR_W-1:0] dptrQ,     dptrD;
    eesu_first_t      firstQ,    firstD;
    logic             irqQ,      irqD;
    logic [15:0]      rdQ,       rdD;
    logic             sampFltQ,  sampFltD;

    logic [15:0]      setRaw;
    logic [15:0]      setRec;
    logic [15:0]      clrVec;
    logic             wrFlags;
    logic             dmaEvent;
    logic             fetchInvalid;
    logic [7:0]       acmdHeld;
    logic             acmdRise;
    logic             acmdClr;

    // ======================================================================
    // Auto-command error holding copy

    // The copy is reloaded from the current error bits when software clears bit 8 and no new edge is recorded
    assign acmdClr = wrFlags && regWrData[EESU_BIT_ACMD] && !setRec[EESU_BIT_ACMD]; // [RULE_16]

    eesu_acmd_hold u_acmd (
        .core_clk    (core_clk),
        .rst_b       (rst_b),
        .ce          (ce),
        .acmdErrBits (acmdErrBits),
        .acmdIsCmd12 (acmdIsCmd12),
        .clearReq    (acmdClr),
        .acmdHeld    (acmdHeld),
        .acmdRise    (acmdRise)
    );

    // ======================================================================
    // Event vector

    // Response, tuning and auto-command sources are qualified by bus mode before recording
    always_comb begin
        fetchInvalid = descFetchInvalid && (dmaState == EESU_DMA_FETCH_DESCRIPTOR_STATE);
        dmaEvent     = dmaErr || fetchInvalid;                           // [RULE_13]
        setRaw       = 16'h0000;
        setRaw[15:EESU_BIT_VENDOR_LO] = vendorErr;                        // [RULE_04]
        setRaw[EESU_BIT_RESP] = primaryMode && respCheckEn && respErr;    // [RULE_05]
        // Faults while tuning runs are routed elsewhere, not to bit 10
        setRaw[EESU_BIT_TUNE] = hsSeMode && tuningFault && !tuningActive; // [RULE_06] [RULE_07]
        setRaw[EESU_BIT_DMA]  = dmaEvent;                                 // [RULE_11]
        setRaw[EESU_BIT_ACMD] = primaryMode && acmdRise;                  // [RULE_14]
        // Only bits enabled for recording may set
        setRec  = setRaw & statEnQ;                                       // [RULE_01]
    end

    // ======================================================================
    // Flag, enable and diagnosis registers

    assign wrFlags = regWrStb && eesu_hit(regAddr, EESU_OFF_FLAGS);

    always_comb begin
        clrVec   = wrFlags ? (regWrData & EESU_IMPL_MASK) : 16'h0000;     // [RULE_03]
        flagsD   = eesu_sticky(flagsQ, clrVec, setRec);                   // [RULE_17]
        statEnD  = statEnQ;
        sigEnD   = sigEnQ;
        if (regWrStb && eesu_hit(regAddr, EESU_OFF_STAT_EN)) begin
            statEnD = regWrData & EESU_IMPL_MASK;
        end
        if (regWrStb && eesu_hit(regAddr, EESU_OFF_SIG_EN)) begin
            sigEnD = regWrData & EESU_IMPL_MASK;
        end
        // Engine state and pointer are frozen at the error for diagnosis
        dmaStD = dmaStQ;
        dptrD  = dptrQ;
        if (setRec[EESU_BIT_DMA]) begin
            dmaStD = fetchInvalid ? EESU_DMA_FETCH_DESCRIPTOR_STATE : dmaState; // [RULE_13]
            dptrD  = descAddr;                                            // [RULE_12]
        end
        // First-error code: tuning wins when several errors arrive together
        firstD = firstQ;
        if (flagsD == 16'h0000) begin
            firstD = EESU_FE_NONE;
        end else if (firstQ == EESU_FE_NONE || setRec[EESU_BIT_TUNE]) begin
            if (setRec[EESU_BIT_TUNE]) begin
                firstD = EESU_FE_TUNE;                                    // [RULE_08]
            end else if (setRec[EESU_BIT_DMA]) begin
                firstD = EESU_FE_DMA;
            end else if (setRec[EESU_BIT_RESP]) begin
                firstD = EESU_FE_RESP;
            end else if (setRec[EESU_BIT_ACMD]) begin
                firstD = EESU_FE_ACMD;
            end else if (setRec != 16'h0000) begin
                firstD = EESU_FE_VENDOR;
            end
        end
        // Interrupt computed from next values so it tracks the flags exactly
        irqD     = |(flagsD & sigEnD);                                    // [RULE_02]
        sampFltD = hsSeMode && tuningFault && tuningActive;               // [RULE_07]
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            flagsQ   <= EESU_RST_FLAGS;
            statEnQ  <= EESU_RST_EN;
            sigEnQ   <= EESU_RST_EN;
            dmaStQ   <= EESU_RST_DMA;
            dptrQ    <= '0;
            firstQ   <= EESU_FE_NONE;
            irqQ     <= 1'b0;
            sampFltQ <= 1'b0;
        end else if (ce) begin
            flagsQ   <= flagsD;
            statEnQ  <= statEnD;
            sigEnQ   <= sigEnD;
            dmaStQ   <= dmaStD;
            dptrQ    <= dptrD;
            firstQ   <= firstD;
            irqQ     <= irqD;
            sampFltQ <= sampFltD;
        end
    end

    // ======================================================================
    // Read path

    // Unmapped addresses return zero; reads have no side effects
    always_comb begin
        rdD = 16'h0000;
        if (regRdStb) begin
            case (regAddr)
                EESU_OFF_FLAGS:   rdD = flagsQ;
                EESU_OFF_STAT_EN: rdD = statEnQ;
                EESU_OFF_SIG_EN:  rdD = sigEnQ;
                EESU_OFF_ACMD:    rdD = {8'h00, acmdHeld};
                EESU_OFF_FIRST:   rdD = {13'h0000, firstQ};
                EESU_OFF_DMA_ST:  rdD = {13'h0000, dmaStQ};
                EESU_OFF_DPTR_LO: rdD = dptrQ[15:0];
                EESU_OFF_DPTR_HI: rdD = dptrQ[31:16];
                default:          rdD = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rdQ <= 16'h0000;
        end else if (ce) begin
            rdQ <= rdD;
        end
    end

    assign regRdData      = rdQ;
    assign irq            = irqQ;
    assign sampleSelFault = sampFltQ;

    // ======================================================================
    // Checks

    generate
        for (genvar b = 8; b < 16; b++) begin : g_chk
            // An enabled event always lands in its flag
            a_set_records : assert property (@(posedge core_clk) // [RULE_01] [RULE_17]
                disable iff (!rst_b) (ce && setRaw[b] && statEnQ[b]) |=> flagsQ[b])
                else $error("enabled event did not set its flag");
            // A disabled bit stays clear whatever its source does
            a_gate_blocks : assert property (@(posedge core_clk) // [RULE_01]
                disable iff (!rst_b) (ce && !flagsQ[b] && !statEnQ[b]) |=> !flagsQ[b])
                else $error("flag set while its status enable was clear");
            // A one written with no same-cycle event clears the bit
            a_w1c_clears : assert property (@(posedge core_clk) // [RULE_03]
                disable iff (!rst_b) (ce && wrFlags && regWrData[b] && !setRec[b])
                |=> !flagsQ[b])
                else $error("write of one did not clear the flag");
            // Only a written one may drop a set bit
            a_w0_keeps : assert property (@(posedge core_clk) // [RULE_17]
                disable iff (!rst_b) (ce && flagsQ[b] && !(wrFlags && regWrData[b]))
                |=> flagsQ[b])
                else $error("flag dropped without a clearing write");
        end
    endgenerate

    // The level output matches the flags and signal enables in the same cycle
    a_irq_level : assert property (@(posedge core_clk) disable iff (!rst_b) // [RULE_02]
        ##1 (irq == |($past(flagsD) & $past(sigEnD)) || !$past(ce)))
        else $error("interrupt does not match flags and signal enables");

    // A fault while tuning runs never reaches the tuning flag
    a_tune_busy : assert property (@(posedge core_clk) disable iff (!rst_b) // [RULE_07]
        (ce && tuningActive && !flagsQ[EESU_BIT_TUNE]) |=> !flagsQ[EESU_BIT_TUNE])
        else $error("tuning flag set while tuning was running");

    // The same fault during tuning goes to the sampling clock choice
    a_tune_choice : assert property (@(posedge core_clk) disable iff (!rst_b) // [RULE_07]
        (ce && hsSeMode && tuningFault && tuningActive) |=> sampleSelFault)
        else $error("fault during tuning not passed to the sampling choice");

    // Outside the high-speed single-ended mode the tuning flag never sets
    a_tune_mode : assert property (@(posedge core_clk) disable iff (!rst_b) // [RULE_06]
        (ce && !flagsQ[EESU_BIT_TUNE] && !hsSeMode) |=> !flagsQ[EESU_BIT_TUNE])
        else $error("tuning flag set outside its bus mode");

    // Tuning takes the leading-error code whenever it is recorded
    a_tune_first : assert property (@(posedge core_clk) disable iff (!rst_b) // [RULE_08]
        (ce && setRec[EESU_BIT_TUNE]) |=> firstQ == EESU_FE_TUNE)
        else $error("tuning error not reported as the leading error");

    // An invalid descriptor in the fetch state raises the fault and shows that state
    a_fetch_state : assert property (@(posedge core_clk) disable iff (!rst_b) // [RULE_13]
        (ce && fetchInvalid && statEnQ[EESU_BIT_DMA])
            |=> flagsQ[EESU_BIT_DMA] && dmaStQ == EESU_DMA_FETCH_DESCRIPTOR_STATE)
        else $error("invalid descriptor did not raise the DMA fault");

    // The pointer takes the descriptor address present when the fault is recorded
    a_dma_capture : assert property (@(posedge core_clk) disable iff (!rst_b) // [RULE_12]
        (ce && setRec[EESU_BIT_DMA]) |=> dptrQ == $past(descAddr))
        else $error("descriptor pointer not captured at the DMA fault");

    // Response errors count only in primary mode with checking on
    a_resp_mode : assert property (@(posedge core_clk) disable iff (!rst_b) // [RULE_05]
        (ce && !flagsQ[EESU_BIT_RESP] && !(primaryMode && respCheckEn))
            |=> !flagsQ[EESU_BIT_RESP])
        else $error("response error set outside primary mode or check disabled");

    // The auto-command flag belongs to primary mode alone
    a_acmd_mode : assert property (@(posedge core_clk) disable iff (!rst_b) // [RULE_14]
        (ce && !flagsQ[EESU_BIT_ACMD] && !primaryMode) |=> !flagsQ[EESU_BIT_ACMD])
        else $error("auto-command flag set outside primary mode");

    // No captured auto-command bit is lost while the flag stands
    a_acmd_holds : assert property (@(posedge core_clk) disable iff (!rst_b) // [RULE_16]
        (ce && flagsQ[EESU_BIT_ACMD] && !acmdClr)
            |=> (acmdHeld & $past(acmdHeld)) == $past(acmdHeld))
        else $error("auto-command copy lost while its flag was set");

endmodule : eesu_top

// [logic/eesu_pkg.sv]
// Constants for the upper error-event status and interrupt block
// ==========================================================================
// Operation
// (RULE_01) A status bit is recorded only when its status-enable bit is set.
// (RULE_02) Interrupt is high while any status bit and its signal-enable bit are set.
// (RULE_03) Writing 1 clears a status bit, writing 0 leaves it; many per write.
// (RULE_04) Bits 15 to 12 are implementation error flags, also write-one-to-clear.
// (RULE_05) Primary mode with response check enabled: response error sets bit 11.
// (RULE_06) Unrecoverable tuning-circuit fault sets bit 10, high-speed single-ended mode only.
// (RULE_07) Faults during tuning skip bit 10 and go to the sampling clock choice.
// (RULE_08) Tuning error outranks every other error raised during a data transfer.
// (RULE_09) Software writes 0 to the sampling clock choice before tuning.
// (RULE_10) Software aborts the command, retunes and retries the data after a tuning error.
// (RULE_11) A descriptor-DMA engine error sets bit 9 in either bus mode.
// (RULE_12) A DMA error captures engine state; descriptor pointer stays readable.
// (RULE_13) An invalid descriptor in the fetch state raises the DMA error.
// (RULE_14) Primary mode: a 0-to-1 on auto-command error bits 0..5 sets bit 8.
// (RULE_15) Auto-command error bit 7 counts only when the auto command was CMD12.
// (RULE_16) Auto-command error copy holds while bit 8 is set, clears with it.
// (RULE_17) Status bits stay set until cleared; a set beats a same-cycle clear.
package eesu_pkg;

    // ======================================================================
    // Register byte offsets
    localparam logic [7:0] EESU_OFF_FLAGS    = 8'h32;
    localparam logic [7:0] EESU_OFF_STAT_EN  = 8'h36;
    localparam logic [7:0] EESU_OFF_SIG_EN   = 8'h3a;
    localparam logic [7:0] EESU_OFF_ACMD     = 8'h3c;
    localparam logic [7:0] EESU_OFF_FIRST    = 8'h40;
    localparam logic [7:0] EESU_OFF_DMA_ST   = 8'h54;
    localparam logic [7:0] EESU_OFF_DPTR_LO  = 8'h58;
    localparam logic [7:0] EESU_OFF_DPTR_HI  = 8'h5a;

    // ======================================================================
    // Field positions of the flag register and of the auto-command error bits
    localparam int EESU_BIT_VENDOR_LO = 12;
    localparam int EESU_BIT_RESP      = 11;
    localparam int EESU_BIT_TUNE      = 10;
    localparam int EESU_BIT_DMA       = 9;
    localparam int EESU_BIT_ACMD      = 8;
    localparam int EESU_ACMD_RISE_TOP = 5;
    localparam int EESU_ACMD_BIT_C12  = 7;

    // Bits owned by this block; the lower byte reads as zero
    localparam logic [15:0] EESU_IMPL_MASK = 16'hff00;

    // ======================================================================
    // Reset values
    localparam logic [15:0] EESU_RST_FLAGS = 16'h0000;
    localparam logic [15:0] EESU_RST_EN    = 16'h0000;
    localparam logic [7:0]  EESU_RST_ACMD  = 8'h00;
    localparam logic [2:0]  EESU_RST_DMA   = 3'h0;

    // ======================================================================
    // DMA engine state code for the fetch-descriptor state
    localparam logic [2:0] EESU_DMA_FETCH_DESCRIPTOR_STATE = 3'h1;

    // Codes of the first-error field, highest priority first
    typedef enum logic [2:0] {
        EESU_FE_NONE   = 3'h0,
        EESU_FE_TUNE   = 3'h1,
        EESU_FE_DMA    = 3'h2,
        EESU_FE_RESP   = 3'h3,
        EESU_FE_ACMD   = 3'h4,
        EESU_FE_VENDOR = 3'h5
    } eesu_first_t;

endpackage : eesu_pkg

// [logic/eesu_acmd_hold.sv]
// Holding copy of the auto-command error bits with 0-to-1 detection
`timescale 1ns/1ps
module eesu_acmd_hold
    import eesu_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       rst_b,
    input  wire logic       ce,
    input  wire logic [7:0] acmdErrBits,
    input  wire logic       acmdIsCmd12,
    input  wire logic       clearReq,
    output logic      [7:0] acmdHeld,
    output logic            acmdRise
);

    logic [7:0] heldQ;
    logic [7:0] heldD;
    logic [7:0] incoming;
    logic [7:0] risen;

    // Bit 7 only counts for CMD12; risen bits are those newly going high
    always_comb begin
        incoming = acmdErrBits;
        if (!acmdIsCmd12) begin
            incoming[EESU_ACMD_BIT_C12] = 1'b0;                 // [RULE_15]
        end
        risen = incoming & ~heldQ;
        // A fresh error wins over the clear so no edge is lost
        heldD = clearReq ? incoming : (heldQ | incoming);       // [RULE_16]
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            heldQ <= EESU_RST_ACMD;
        end else if (ce) begin
            heldQ <= heldD;
        end
    end

    assign acmdHeld = heldQ;
    assign acmdRise = |risen[EESU_ACMD_RISE_TOP:0];             // [RULE_14]

    // Bit 7 never captured unless the command was CMD12
    a_acmd_c12_gate : assert property (@(posedge core_clk) disable iff (!rst_b) // [RULE_15]
        (ce && !clearReq && !heldQ[7] && !acmdIsCmd12) |=> !heldQ[7])
        else $error("auto-command bit 7 captured for a non-CMD12 command");

endmodule : eesu_acmd_hold

// [bench/tb_top.sv]
// Self-checking bench for the upper error-event status and interrupt block
`timescale 1ns/1ps
module tb_top
    import eesu_pkg::*;
;

    // ======================================================================
    // Signals and counters
    logic        core_clk;
    logic        rst_b;
    logic        ce;
    logic [7:0]  regAddr;
    logic [15:0] regWrData;
    logic        regWrStb;
    logic        regRdStb;
    logic [15:0] regRdData;
    logic        irq;
    logic        primaryMode;
    logic        hsSeMode;
    logic        respCheckEn;
    logic [3:0]  vendorErr;
    logic        respErr;
    logic        tuningFault;
    logic        tuningActive;
    logic        dmaErr;
    logic        descFetchInvalid;
    logic [2:0]  dmaState;
    logic [31:0] descAddr;
    logic [7:0]  acmdErrBits;
    logic        acmdIsCmd12;
    logic        sampleSelFault;
    logic        selSeen;
    int          badCount;
    int          checked;

    // Event selector bits for the pulse task
    localparam logic [7:0] P_VEN = 8'h0f;
    localparam logic [7:0] P_RSP = 8'h10;
    localparam logic [7:0] P_TUN = 8'h20;
    localparam logic [7:0] P_DMA = 8'h40;
    localparam logic [7:0] P_FET = 8'h80;

    eesu_top #(.PTR_W(32)) i_eesu_top (
        .core_clk(core_clk), .rst_b(rst_b), .ce(ce), .regAddr(regAddr),
        .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
        .regRdData(regRdData), .irq(irq), .primaryMode(primaryMode), .hsSeMode(hsSeMode),
        .respCheckEn(respCheckEn), .vendorErr(vendorErr), .respErr(respErr),
        .tuningFault(tuningFault), .tuningActive(tuningActive), .dmaErr(dmaErr),
        .descFetchInvalid(descFetchInvalid), .dmaState(dmaState), .descAddr(descAddr),
        .acmdErrBits(acmdErrBits), .acmdIsCmd12(acmdIsCmd12),
        .sampleSelFault(sampleSelFault)
    );

    // ======================================================================
    // Clock
    always #10 core_clk = ~core_clk;

    // ======================================================================
    // Access and check tasks
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
        checked++;
        if (seen !== exp) begin
            badCount++;
            $display("[ERR] %0t %s: seen %h expected %h", $time, what, seen, exp);
        end
    endtask : chk

    // Strobe stays up for exactly one edge, so back-to-back calls never double-drive
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge core_clk);
        regWrStb  <= 1'b1;
        regAddr   <= a;
        regWrData <= d;
        @(posedge core_clk);
        regWrStb  <= 1'b0;
    endtask : wr

    // Read data stands only in the cycle after the strobe, so sample just past that edge
    task automatic rd(input logic [7:0] a, input logic [15:0] exp, input string what);
        @(posedge core_clk);
        regRdStb <= 1'b1;
        regAddr  <= a;
        @(posedge core_clk);
        regRdStb <= 1'b0;
        #1 chk(regRdData, exp, what);
    endtask : rd

    // One-cycle event pulse; the sampling-choice fault is a one-cycle pulse too
    task automatic pulse(input logic [7:0] sel);
        @(posedge core_clk);
        vendorErr        <= sel[3:0];
        respErr          <= sel[4];
        tuningFault      <= sel[5];
        dmaErr           <= sel[6];
        descFetchInvalid <= sel[7];
        @(posedge core_clk);
        vendorErr        <= 4'h0;
        {respErr, tuningFault, dmaErr, descFetchInvalid} <= 4'h0;
        #1 selSeen = sampleSelFault;
    endtask : pulse

    task automatic mode(input logic p, input logic h, input logic r, input logic t);
        @(posedge core_clk);
        primaryMode  <= p;
        hsSeMode     <= h;
        respCheckEn  <= r;
        tuningActive <= t;
    endtask : mode

    task automatic finalReport;
        $display("Comparisons %0d, mismatches %0d", checked, badCount);
        if (badCount == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : finalReport

    // ======================================================================
    // Hang guard: no scenario needs anywhere near this many cycles
    initial begin
        repeat (5000) @(posedge core_clk);
        badCount++;
        finalReport();
    end

    // ======================================================================
    // Main sequence
    initial begin
        {core_clk, rst_b, regWrStb, regRdStb, respErr, tuningFault} = '0;
        {tuningActive, dmaErr, descFetchInvalid, acmdIsCmd12, selSeen} = '0;
        {primaryMode, hsSeMode, respCheckEn} = '0;
        {regAddr, regWrData, vendorErr, dmaState, descAddr, acmdErrBits} = '0;
        ce = 1'b1;
        badCount = 0;
        checked = 0;
        repeat (20) @(posedge core_clk);
        rst_b <= 1'b1;
        // Reset values, unmapped place and interrupt idle
        rd(EESU_OFF_FLAGS, EESU_RST_FLAGS, "flags reset");
        rd(EESU_OFF_STAT_EN, EESU_RST_EN, "status enable reset");
        rd(EESU_OFF_SIG_EN, EESU_RST_EN, "signal enable reset");
        rd(EESU_OFF_ACMD, {8'h00, EESU_RST_ACMD}, "auto-cmd copy reset");
        rd(EESU_OFF_DMA_ST, {13'h0000, EESU_RST_DMA}, "dma state reset");
        rd(8'h10, 16'h0000, "unmapped read");
        chk({15'h0000, irq}, 16'h0000, "irq reset");
        // Signal enable alone neither records nor interrupts
        wr(EESU_OFF_SIG_EN, 16'hffff);
        rd(EESU_OFF_SIG_EN, 16'hff00, "signal enable low byte");
        pulse(P_DMA);
        rd(EESU_OFF_FLAGS, 16'h0000, "unrecorded with status disabled");
        chk({15'h0000, irq}, 16'h0000, "irq with nothing recorded");
        // Per-bit status gating on the implementation bits
        wr(EESU_OFF_STAT_EN, 16'hef00);
        wr(EESU_OFF_SIG_EN, 16'h0000);
        pulse(P_VEN);
        rd(EESU_OFF_FLAGS, 16'he000, "vendor bits gated");
        chk({15'h0000, irq}, 16'h0000, "irq with signal disabled");
        wr(EESU_OFF_SIG_EN, 16'h2000);
        rd(EESU_OFF_SIG_EN, 16'h2000, "signal enable");
        chk({15'h0000, irq}, 16'h0001, "irq raised");
        wr(EESU_OFF_FLAGS, 16'h2000);
        rd(EESU_OFF_FLAGS, 16'hc000, "single clear");
        chk({15'h0000, irq}, 16'h0000, "irq dropped");
        wr(EESU_OFF_FLAGS, 16'hc0ff);
        rd(EESU_OFF_FLAGS, 16'h0000, "multi clear");
        wr(EESU_OFF_STAT_EN, 16'hff00);
        // Response check only in primary mode with checking on
        mode(1'b0, 1'b0, 1'b1, 1'b0);
        pulse(P_RSP);
        mode(1'b1, 1'b0, 1'b0, 1'b0);
        pulse(P_RSP);
        rd(EESU_OFF_FLAGS, 16'h0000, "response refused");
        mode(1'b1, 1'b0, 1'b1, 1'b0);
        pulse(P_RSP);
        rd(EESU_OFF_FLAGS, 16'h0800, "response error");
        wr(EESU_OFF_FLAGS, 16'h0800);
        // Tuning fault: wrong mode, during tuning, then for real
        mode(1'b0, 1'b0, 1'b0, 1'b0);
        pulse(P_TUN);
        rd(EESU_OFF_FLAGS, 16'h0000, "tuning outside mode");
        // The sampling choice lives outside this block and starts from zero
        mode(1'b0, 1'b1, 1'b0, 1'b1);
        pulse(P_TUN);
        chk({15'h0000, selSeen}, 16'h0001, "fault during tuning");
        rd(EESU_OFF_FLAGS, 16'h0000, "no tuning flag during tuning");
        mode(1'b0, 1'b1, 1'b0, 1'b0);
        pulse(P_DMA);
        rd(EESU_OFF_FIRST, {13'h0000, EESU_FE_DMA}, "first error dma");
        pulse(P_TUN);
        chk({15'h0000, selSeen}, 16'h0000, "no choice fault outside tuning");
        rd(EESU_OFF_FLAGS, 16'h0600, "tuning flag");
        rd(EESU_OFF_FIRST, {13'h0000, EESU_FE_TUNE}, "tuning outranks");
        // The driver answers a tuning error by retuning, then clears the flags
        mode(1'b0, 1'b1, 1'b0, 1'b1);
        mode(1'b0, 1'b1, 1'b0, 1'b0);
        wr(EESU_OFF_FLAGS, 16'h0600);
        rd(EESU_OFF_FIRST, {13'h0000, EESU_FE_NONE}, "first error cleared");
        // Descriptor-DMA error capture, with primary mode off
        @(posedge core_clk);
        dmaState <= 3'h5;
        descAddr <= 32'h1234_5678;
        pulse(P_DMA);
        rd(EESU_OFF_FLAGS, 16'h0200, "dma error");
        rd(EESU_OFF_DMA_ST, 16'h0005, "dma state captured");
        rd(EESU_OFF_DPTR_LO, 16'h5678, "pointer low");
        rd(EESU_OFF_DPTR_HI, 16'h1234, "pointer high");
        wr(EESU_OFF_DMA_ST, 16'h0007);
        rd(EESU_OFF_DMA_ST, 16'h0005, "dma state read-only");
        wr(EESU_OFF_FLAGS, 16'h0200);
        // Invalid descriptor counts only in the fetch state
        @(posedge core_clk);
        dmaState <= 3'h2;
        pulse(P_FET);
        rd(EESU_OFF_FLAGS, 16'h0000, "invalid outside fetch");
        @(posedge core_clk);
        dmaState <= EESU_DMA_FETCH_DESCRIPTOR_STATE;
        pulse(P_FET);
        rd(EESU_OFF_FLAGS, 16'h0200, "invalid in fetch");
        rd(EESU_OFF_DMA_ST, 16'h0001, "fetch state shown");
        // A set in the same cycle as its clear wins
        @(posedge core_clk);
        regWrStb  <= 1'b1;
        regAddr   <= EESU_OFF_FLAGS;
        regWrData <= 16'h0200;
        dmaErr    <= 1'b1;
        @(posedge core_clk);
        regWrStb  <= 1'b0;
        dmaErr    <= 1'b0;
        repeat (5) @(posedge core_clk);
        rd(EESU_OFF_FLAGS, 16'h0200, "set beats clear");
        wr(EESU_OFF_FLAGS, 16'h0200);
        // Auto-command errors in primary mode, then outside it
        mode(1'b1, 1'b0, 1'b0, 1'b0);
        @(posedge core_clk);
        acmdErrBits <= 8'h84;
        acmdIsCmd12 <= 1'b0;
        rd(EESU_OFF_FLAGS, 16'h0100, "auto-cmd rise");
        rd(EESU_OFF_ACMD, 16'h0004, "bit7 masked");
        @(posedge core_clk);
        acmdIsCmd12 <= 1'b1;
        rd(EESU_OFF_ACMD, 16'h0084, "bit7 with CMD12");
        @(posedge core_clk);
        acmdErrBits <= 8'h00;
        rd(EESU_OFF_ACMD, 16'h0084, "copy held");
        wr(EESU_OFF_FLAGS, 16'h0100);
        rd(EESU_OFF_FLAGS, 16'h0000, "auto-cmd cleared");
        rd(EESU_OFF_ACMD, 16'h0000, "copy reloaded");
        mode(1'b0, 1'b0, 1'b0, 1'b0);
        @(posedge core_clk);
        acmdErrBits <= 8'h20;
        rd(EESU_OFF_FLAGS, 16'h0000, "auto-cmd outside primary");
        // Clock enable low freezes the block, so an event then is lost
        @(posedge core_clk);
        ce <= 1'b0;
        pulse(P_VEN);
        @(posedge core_clk);
        ce <= 1'b1;
        rd(EESU_OFF_FLAGS, 16'h0000, "event lost while frozen");
        finalReport();
    end

endmodule : tb_top
